/* hw/adc_sequencing_control.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control
   import adc_ctrl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [11:0] sar_result,
   output logic             converter_reset,
   output logic             converter_power_down,
   output logic             conv_clk_en,
   output logic             bandgap_power,
   output logic             bandgap_connect,
   output logic             ref_source_select,
   output logic             vref_other_off,
   output logic      [11:0] channel_connect,
   output logic      [11:0] analog_pin_sel,
   output logic      [11:0] pullup_disable,
   output logic      [11:0] dir_override,
   output logic             conv_irq
);
   typedef struct packed {
      logic [7:0]  ctrl_one;
      logic [7:0]  ctrl_two;
      logic [7:0]  pin_low;
      logic [3:0]  pin_high;
      logic        irq_en;
      logic        irq_flag;
      logic        supmon;
      logic [11:0] result;
      conv_state_t state;
      logic [4:0]  periods;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        conv_reset;
      logic        clk_en;
      logic        bg_power;
      logic        bg_connect;
      logic        ref_sel;
      logic        vref_off;
      logic [11:0] ch_connect;
      logic [11:0] pin_sel;
      logic [11:0] pu_dis;
      logic [11:0] dir_ovr;
      logic        irq;
   } state_t;

   state_t cur;
   state_t next_cur;

   logic        tick;
   logic [11:0] mux_connect;
   logic [11:0] mux_pullup;
   logic [11:0] mux_dir;
   logic        mux_bg;
   logic        mux_vref;
   logic        mux_vref_off;
   logic        wr_access;
   logic        rd_access;
   logic        acc_start;
   logic        start_now;
   logic        done;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;
   logic [15:0] justified;
   logic        hit;

   conv_clk_prescaler u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .div_sel (cur.ctrl_two[POS_DIVSEL +: 3]),
      .tick    (tick)
   );

   pin_mux_ctrl u_mux (
      .pin_sel            ({cur.pin_high, cur.pin_low}),
      .channel_select     (cur.ctrl_one[POS_CHSEL +: 4]),
      .internal_ref_route (cur.ctrl_two[BIT_IREF]),
      .ref_source_select  (cur.ctrl_two[BIT_REFSEL]),
      .channel_connect    (mux_connect),
      .pullup_disable     (mux_pullup),
      .dir_override       (mux_dir),
      .bandgap_connect    (mux_bg),
      .vref_pin_func      (mux_vref),
      .vref_other_off     (mux_vref_off)
   );

   always_comb begin
      next_cur  = cur;
      // Writes land at the edge the master sees pready high, not before
      acc_start = psel && penable && !cur.pready;
      wr_access = psel && penable && pwrite && cur.pready;
      rd_access = acc_start && !pwrite;
      wbyte     = pstrb[0] ? pwdata[7:0] : 8'h00;
      start_now = cur.ctrl_one[BIT_START];
      done      = 1'b0;
      hit       = 1'b1;
      justified = cur.ctrl_one[BIT_JUSTIFY] ? {4'h0, cur.result}
                                            : {cur.result, 4'h0};
      rbyte     = 8'h00;

      // Conversion sequencer
      case (cur.state)
         ST_IDLE: begin
            if (start_now) begin
               next_cur.state = ST_RESET;
            end
         end
         ST_RESET: begin
            if (!start_now) begin
               next_cur.state   = ST_CONV;
               next_cur.periods = 5'd0;
            end
         end
         ST_CONV: begin
            if (start_now) begin
               next_cur.state = ST_RESET;
            end else if (tick) begin
               if (cur.periods == 5'(CONV_CLOCKS - 1)) begin
                  next_cur.state = ST_IDLE;
                  done = 1'b1;
               end else begin
                  next_cur.periods = cur.periods + 5'd1;
               end
            end
         end
         default: begin
            next_cur.state = ST_IDLE;
         end
      endcase

      if (done) begin
         next_cur.ctrl_one[BIT_BUSY] = 1'b0;
         next_cur.result = sar_result;
      end
      if (start_now) begin
         next_cur.ctrl_one[BIT_BUSY] = 1'b1;
      end

      // APB access, one wait state per transfer
      next_cur.pready  = psel && penable && !cur.pready;
      next_cur.pslverr = 1'b0;
      case (paddr)
         OFFS_CONTROL_ONE: begin
            rbyte = cur.ctrl_one;
         end
         OFFS_CONTROL_TWO: begin
            rbyte = cur.ctrl_two & CTRL_TWO_MASK;
         end
         OFFS_PIN_LOW: begin
            rbyte = cur.pin_low;
         end
         OFFS_PIN_HIGH: begin
            rbyte = {4'h0, cur.pin_high};
         end
         OFFS_RESULT_LOW: begin
            rbyte = justified[7:0];
         end
         OFFS_RESULT_HIGH: begin
            rbyte = justified[15:8];
         end
         OFFS_MISC: begin
            rbyte = {5'h00, cur.supmon, cur.irq_flag, cur.irq_en};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      if (acc_start) begin
         next_cur.pslverr = !hit;
      end
      if (rd_access) begin
         next_cur.prdata  = {24'h00_0000, rbyte};
      end
      if (wr_access) begin
         if (pstrb[0]) begin
            case (paddr)
               OFFS_CONTROL_ONE: begin
                  next_cur.ctrl_one = {wbyte[7], next_cur.ctrl_one[BIT_BUSY],
                                       wbyte[5:0]};
               end
               OFFS_CONTROL_TWO: begin
                  next_cur.ctrl_two = wbyte & CTRL_TWO_MASK;
               end
               OFFS_PIN_LOW: begin
                  next_cur.pin_low = wbyte;
               end
               OFFS_PIN_HIGH: begin
                  next_cur.pin_high = wbyte[3:0];
               end
               OFFS_MISC: begin
                  next_cur.irq_en = wbyte[BIT_IRQ_EN];
                  next_cur.supmon = wbyte[BIT_SUPMON];
                  if (wbyte[BIT_IRQ_FLG]) begin
                     next_cur.irq_flag = 1'b0;
                  end
               end
               default: begin
                  // Unmapped or result registers: no effect; unmapped ones flag an error with pready
               end
            endcase
         end
      end
      if (done) begin
         next_cur.irq_flag = 1'b1;
      end

      // Registered outputs
      next_cur.conv_reset = next_cur.state == ST_RESET;
      next_cur.clk_en     = tick && cur.state == ST_CONV;
      next_cur.bg_power   = (cur.ctrl_two[BIT_BGON] && mux_bg) || cur.supmon;
      next_cur.bg_connect = mux_bg;
      next_cur.ref_sel    = mux_vref;
      next_cur.vref_off   = mux_vref_off;
      next_cur.ch_connect = mux_connect;
      next_cur.pin_sel    = {cur.pin_high, cur.pin_low};
      next_cur.pu_dis     = mux_pullup;
      next_cur.dir_ovr    = mux_dir;
      next_cur.irq        = cur.irq_flag && cur.irq_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur          <= '0;
         cur.ctrl_one <= RST_CONTROL_ONE;
         cur.ctrl_two <= RST_CONTROL_TWO;
         cur.pin_low  <= RST_PIN_LOW;
         cur.pin_high <= RST_PIN_HIGH;
         cur.pin_sel  <= {RST_PIN_HIGH, RST_PIN_LOW};
         cur.pu_dis   <= {RST_PIN_HIGH, RST_PIN_LOW};
         cur.dir_ovr  <= {RST_PIN_HIGH, RST_PIN_LOW};
         cur.ch_connect <= 12'h001;
      end else begin
         cur <= next_cur;
      end
   end

   assign prdata               = cur.prdata;
   assign pready               = cur.pready;
   assign pslverr              = cur.pslverr;
   assign converter_reset      = cur.conv_reset;
   assign converter_power_down = cur.ctrl_one[BIT_PDOWN];
   assign conv_clk_en          = cur.clk_en;
   assign bandgap_power        = cur.bg_power;
   assign bandgap_connect      = cur.bg_connect;
   assign ref_source_select    = cur.ref_sel;
   assign vref_other_off       = cur.vref_off;
   assign channel_connect      = cur.ch_connect;
   assign analog_pin_sel       = cur.pin_sel;
   assign pullup_disable       = cur.pu_dis;
   assign dir_override         = cur.dir_ovr;
   assign conv_irq             = cur.irq;
endmodule
`default_nettype wire

/* hw/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

   // Register word offsets on the APB bus
   localparam logic [11:0] OFFS_CONTROL_ONE  = 12'h000;
   localparam logic [11:0] OFFS_CONTROL_TWO  = 12'h004;
   localparam logic [11:0] OFFS_PIN_LOW      = 12'h008;
   localparam logic [11:0] OFFS_PIN_HIGH     = 12'h00C;
   localparam logic [11:0] OFFS_RESULT_LOW   = 12'h010;
   localparam logic [11:0] OFFS_RESULT_HIGH  = 12'h014;
   localparam logic [11:0] OFFS_MISC         = 12'h018;

   // Control one fields
   localparam int BIT_START   = 7;
   localparam int BIT_BUSY    = 6;
   localparam int BIT_PDOWN   = 5;
   localparam int BIT_JUSTIFY = 4;
   localparam int POS_CHSEL   = 0;
   // Control two fields
   localparam int BIT_IREF    = 7;
   localparam int BIT_BGON    = 6;
   localparam int BIT_REFSEL  = 4;
   localparam int POS_DIVSEL  = 0;
   // Misc register fields
   localparam int BIT_IRQ_EN  = 0;
   localparam int BIT_IRQ_FLG = 1;
   localparam int BIT_SUPMON  = 2;

   // Reset values and control two write mask
   localparam logic [7:0] RST_CONTROL_ONE = 8'h60;
   localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
   localparam logic [7:0] RST_PIN_LOW     = 8'hFF;
   localparam logic [3:0] RST_PIN_HIGH    = 4'hF;
   localparam logic [7:0] CTRL_TWO_MASK   = 8'hD7;

   // Timing and channel counts
   localparam int          CONV_CLOCKS    = 16;
   localparam logic [2:0]  DIV_UNDEFINED  = 3'b111;
   localparam logic [3:0]  CH_LAST        = 4'hB;
   localparam int          NUM_CHANNELS   = 12;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RESET = 2'b01,
      ST_CONV  = 2'b10
   } conv_state_t;

endpackage

/* hw/conv_clk_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module conv_clk_prescaler
   import adc_ctrl_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] div_sel,
   output logic            tick
);
   typedef struct packed {
      logic [5:0] count;
      logic [2:0] last_sel;
      logic       tick;
   } presc_t;

   presc_t cur;
   presc_t next_cur;
   logic [5:0] limit;

   always_comb begin
      next_cur = cur;
      limit = 6'((7'd1 << div_sel) - 7'd1);
      next_cur.last_sel = div_sel;
      next_cur.tick = 1'b0;
      if (div_sel != cur.last_sel || div_sel == DIV_UNDEFINED) begin
         next_cur.count = 6'h00;
      end else if (cur.count >= limit) begin
         next_cur.count = 6'h00;
         next_cur.tick = 1'b1;
      end else begin
         next_cur.count = cur.count + 6'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign tick = cur.tick;
endmodule
`default_nettype wire

/* hw/pin_mux_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_mux_ctrl
   import adc_ctrl_pkg::*;
(
   input  wire logic [11:0] pin_sel,
   input  wire logic [3:0]  channel_select,
   input  wire logic        internal_ref_route,
   input  wire logic        ref_source_select,
   output logic      [11:0] channel_connect,
   output logic      [11:0] pullup_disable,
   output logic      [11:0] dir_override,
   output logic             bandgap_connect,
   output logic             vref_pin_func,
   output logic             vref_other_off
);
   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g++) begin : g_ch
         assign channel_connect[g] = !internal_ref_route
                                     && channel_select == 4'(g);
         assign pullup_disable[g] = pin_sel[g];
         assign dir_override[g]   = pin_sel[g];
      end
   endgenerate
   assign bandgap_connect = internal_ref_route;
   assign vref_pin_func  = ref_source_select;
   assign vref_other_off = ref_source_select;
endmodule
`default_nettype wire

/* verification/adc_sequencing_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_props
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        converter_reset,
   input wire logic        conv_clk_en,
   input wire logic        bandgap_connect,
   input wire logic        ref_source_select,
   input wire logic        vref_other_off,
   input wire logic [11:0] channel_connect,
   input wire logic [11:0] analog_pin_sel,
   input wire logic [11:0] pullup_disable,
   input wire logic [11:0] dir_override,
   input wire logic        conv_irq
);
   logic [4:0] tick_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Saturates, so a runaway tick stream cannot wrap back to 16
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tick_cnt <= 5'h00;
      else if ($rose(converter_reset))
         tick_cnt <= 5'h00;
      else if (conv_clk_en && tick_cnt != 5'h1F)
         tick_cnt <= tick_cnt + 5'h01;
   end
   sequence conv_end;
      $rose(conv_irq);
   endsequence
   sequence start_held;
      converter_reset ##1 converter_reset;
   endsequence
   sequence bus_quiet;
      (!psel)[*2] ##0 (conv_irq && !converter_reset);
   endsequence
   a_route_cuts_ch: assert property (
      bandgap_connect |-> channel_connect == 12'h000)
      else $error("channel connected while bandgap routed");
   a_vref_takeover: assert property (
      vref_other_off == ref_source_select)
      else $error("shared pin not taken over by reference");
   a_pin_override: assert property (
      pullup_disable == analog_pin_sel && dir_override == analog_pin_sel)
      else $error("analog pin keeps pull-up or direction");
   a_chan_onehot: assert property (
      !bandgap_connect |-> $onehot0(channel_connect))
      else $error("more than one channel connected");
   a_reset_idle: assert property (
      start_held |-> !conv_clk_en)
      else $error("conversion clock runs while held in reset");
   a_sixteen_ticks: assert property (
      conv_end |-> tick_cnt == 5'h10)
      else $error("conversion end not after sixteen ticks");
   a_pins_at_reset: assert property (
      $rose(presetn) |-> analog_pin_sel == 12'hFFF)
      else $error("pin enables not all set after reset");
   a_irq_sticky: assert property (
      bus_quiet |=> conv_irq)
      else $error("interrupt dropped without a bus write");
endmodule
bind adc_sequencing_control adc_seq_props props_u (
   .pclk(pclk), .presetn(presetn), .psel(psel),
   .converter_reset(converter_reset), .conv_clk_en(conv_clk_en),
   .bandgap_connect(bandgap_connect),
   .ref_source_select(ref_source_select),
   .vref_other_off(vref_other_off), .channel_connect(channel_connect),
   .analog_pin_sel(analog_pin_sel), .pullup_disable(pullup_disable),
   .dir_override(dir_override), .conv_irq(conv_irq));
`default_nettype wire

/* verification/adc_sequencing_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control_tb import adc_ctrl_pkg::*;;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  pstrb = 4'hF;
   logic [11:0] sar_result = 12'h000;
   logic [31:0] prdata, rd, v;
   logic [31:0] seed = 32'h4973_3e8e;
   logic        pready, pslverr, converter_reset, converter_power_down;
   logic        conv_clk_en, bandgap_power, bandgap_connect, slv, j;
   logic        ref_source_select, vref_other_off, conv_irq;
   logic [11:0] channel_connect, analog_pin_sel, pullup_disable;
   logic [11:0] dir_override;
   logic [7:0]  c1;
   logic [7:0]  ctl2 [4] = '{8'h40, 8'hFF, 8'hD0, 8'h10};
   logic [11:0] model_q [$];
   logic [11:0] r;
   int          err_total = 0;
   int          checks_done = 0;
   int          n;

   adc_sequencing_control dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sar_result(sar_result), .converter_reset(converter_reset),
      .converter_power_down(converter_power_down),
      .conv_clk_en(conv_clk_en), .bandgap_power(bandgap_power),
      .bandgap_connect(bandgap_connect),
      .ref_source_select(ref_source_select),
      .vref_other_off(vref_other_off), .channel_connect(channel_connect),
      .analog_pin_sel(analog_pin_sel), .pullup_disable(pullup_disable),
      .dir_override(dir_override), .conv_irq(conv_irq));

   always #4 pclk = ~pclk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Holds the request until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         err_total++;
         stop_test();
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a,
                        input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, rd, {24'h00_0000, e});
   endtask

   task automatic stop_test();
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      err_total++;
      stop_test();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("ctrl1", OFFS_CONTROL_ONE, 8'h60);
      rdchk("pinl", OFFS_PIN_LOW, 8'hFF);
      rdchk("pinh", OFFS_PIN_HIGH, 8'h0F);
      v = rnd();
      apb(1'b1, OFFS_PIN_LOW, v[7:0]);
      apb(1'b1, OFFS_PIN_HIGH, v[15:8]);
      rdchk("pinh", OFFS_PIN_HIGH, {4'h0, v[11:8]});
      chk("pinsel", {20'h0_0000, analog_pin_sel}, {20'h0_0000, v[11:0]});
      foreach (ctl2[i]) begin
         apb(1'b1, OFFS_CONTROL_TWO, ctl2[i]);
         repeat (4) @(posedge pclk);
         rdchk("ctrl2", OFFS_CONTROL_TWO, ctl2[i] & 8'hD7);
         chk("refsel", ref_source_select, ctl2[i][4]);
         chk("vrefoff", vref_other_off, ctl2[i][4]);
         chk("bgconn", bandgap_connect, ctl2[i][7]);
         chk("bgpwr", bandgap_power, ctl2[i][7] & ctl2[i][6]);
      end
      apb(1'b0, 12'h01C, 8'h00);
      chk("slverr", slv, 1'b1);
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, OFFS_CONTROL_ONE, 8'(c));
         repeat (3) @(posedge pclk);
         chk("chan", channel_connect, c < 12 ? 32'h1 << c : 32'h0);
      end
      apb(1'b1, OFFS_MISC, 8'h01);
      // Every divider code except the undefined 7 times the sequencer
      for (int d = 0; d < 7; d++) begin
         j = d[0];
         c1 = {3'b000, j, 4'(d)};
         v = rnd();
         sar_result <= v[11:0];
         model_q.push_back(v[11:0]);
         apb(1'b1, OFFS_CONTROL_TWO, 8'(d));
         apb(1'b1, OFFS_CONTROL_ONE, c1);
         repeat (8) @(posedge pclk);
         chk("pdown", converter_power_down, 1'b0);
         apb(1'b1, OFFS_CONTROL_ONE, 8'h80 | c1);
         rdchk("busy", OFFS_CONTROL_ONE, 8'hC0 | c1);
         chk("cvreset", converter_reset, 1'b1);
         apb(1'b1, OFFS_CONTROL_ONE, c1);
         n = 0;
         while (conv_irq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
         end
         // A late sample change must not reach the result
         sar_result <= ~v[11:0];
         r = model_q.pop_front();
         chk("convlen", n >= 15 << d && n <= (16 << d) + 8, 1);
         rdchk("busy0", OFFS_CONTROL_ONE, c1);
         rdchk("resl", OFFS_RESULT_LOW, j ? r[7:0] : {r[3:0], 4'h0});
         rdchk("resh", OFFS_RESULT_HIGH, j ? {4'h0, r[11:8]} : r[11:4]);
         apb(1'b1, OFFS_MISC, 8'h03);
         repeat (3) @(posedge pclk);
         chk("irqclr", conv_irq, 1'b0);
      end
      apb(1'b1, OFFS_CONTROL_ONE, 8'h20);
      repeat (2) @(posedge pclk);
      chk("pdown", converter_power_down, 1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
